// File: hdl/mft_defines.svh
`ifndef MFT_DEFINES_SVH
`define MFT_DEFINES_SVH
// Timer register index, low nibble of the timer bus address
`define MFT_R_COUNT 4'h0
`define MFT_R_CCA 4'h1
`define MFT_R_CCB 4'h2
`define MFT_R_CCC 4'h3
`define MFT_R_CCD 4'h4
`define MFT_R_CTRL 4'h5
`define MFT_R_IOC 4'h6
`define MFT_R_STAT 4'h7
`define MFT_R_MODE 4'h8
// Channel control bits
`define MFT_C_RUN 0
`define MFT_C_CLRA 1
`define MFT_C_CAPA 2
`define MFT_C_BUFC 3
`define MFT_C_BUFD 4
`define MFT_C_DOWN 5
`define MFT_C_CASC 6
`define MFT_C_CAPSRC 7
`define MFT_C_CAPB 8
`define MFT_CTRL_W 9
// I/O control bits
`define MFT_IO_LVLA 0
`define MFT_IO_LVLC 1
`define MFT_IO_INITA 2
`define MFT_IO_INITC 3
// Status bits
`define MFT_S_FLAGA 0
`define MFT_S_OVF 1
`define MFT_S_UNF 2
// Reset values
`define MFT_CTRL_RST 9'h000
`define MFT_IOC_RST 4'h0
`define MFT_CC_RST 16'hFFFF
// Controller register byte offsets on AHB-Lite
`define MFT_H_ADDR 8'h00
`define MFT_H_WDATA 8'h04
`define MFT_H_GO 8'h08
`define MFT_H_RDATA 8'h0C
`define MFT_H_PIN 8'h10
// Pin config fields: timer select, port level, port enable
`define MFT_P_SEL 0
`define MFT_P_LVL 8
`define MFT_P_OE 16
`endif

// File: hdl/mft_pkg.sv
package mft_pkg;
  // Operating mode of one channel
  typedef enum logic [1:0] {MFT_NORMAL, MFT_PWM1, MFT_PWM2, MFT_PHASE} mft_mode_e;
  // Controller bus cycle states
  typedef enum logic [1:0] {MFT_IDLE, MFT_T1, MFT_T2, MFT_DONE} mft_bus_e;
  typedef logic [15:0] mft_word_t;
endpackage

// File: hdl/mft_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mft_if (
  input wire logic hclk,   // Common clock
  input wire logic hresetn // Async reset, active low
);
  import mft_pkg::*;
  logic t1;           // First state of a bus cycle
  logic t2;           // Second state, write data valid
  logic wr;           // Cycle is a write
  logic [5:0] addr;   // Channel and register index
  mft_word_t wdata;   // Write data
  mft_word_t rdata;   // Read data, valid after T2
  logic [2:0] tpin_a; // Timer level of pin A per channel
  logic [2:0] tpin_c; // Timer level of pin C per channel
  modport dev (input t1, t2, wr, addr, wdata, output rdata, tpin_a, tpin_c);
  modport cpu (output t1, t2, wr, addr, wdata, input rdata, tpin_a, tpin_c);
endinterface
`default_nettype wire

// File: hdl/mft_flag.sv
`timescale 1ns/1ps
`default_nettype none
module mft_flag (
  input wire logic hclk,    // Clock
  input wire logic hresetn, // Async reset, active low
  input wire logic set,     // Event pulse
  input wire logic rd,      // Status read strobe
  input wire logic wr0,     // Status write with this bit 0
  input wire logic dma_clr, // Automatic clear by DMA trigger
  output logic flag         // Sticky flag
);
  logic armed; // Flag was read as 1 since last write of 0

  // Remember the read value so a write of 0 clears only after a read of 1; dma_clr clears without a read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed <= 1'b0;
    end else if (rd) begin
      armed <= flag; // [R22]
    end else if (wr0) begin
      armed <= 1'b0;
    end
  end

  // Event set wins over any clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if ((wr0 && armed) || dma_clr) begin
      flag <= 1'b0; // [R22]
    end
  end
endmodule
`default_nettype wire

// File: hdl/mft_timer.sv
// Notes on behaviour
// R1 - Clear on match gives period N plus one
// R2 - Clear beats counter write in T2
// R3 - Counter write in T2 beats increment
// R4 - Buffer transfer still done; channel 0 new data
// R5 - Capture in read T1 returns fresh value
// R6 - Capture beats capture register write in T2
// R7 - Capture buffer shift beats buffer write
// R8 - Compare write stored, match still issued
// R9 - Cascade: channel 2 write suppresses channel 1 count
// R10 - Cascade contention keeps matches and captures alive
// R11 - Software keeps cascade clear settings consistent
// R12 - Clear with overflow/underflow sets no flag
// R13 - Write during wrapping count sets no flag
// R14 - PWM1 pairs A/B on pin A, C/D on C
// R15 - PWM1 with C/D buffer freezes pin C
// R16 - Channel 0 with only D buffer keeps pin C
// R17 - Software buffers both C and D on channel 0
// R18 - Normal, PWM1, PWM2 everywhere; phase on 1, 2
// R19 - Pins low on reset and standby
// R20 - Software sets levels before pin selection
// R21 - Software cuts output via port on error
// R22 - Flag clears by read 1 then write 0
// R23 - One winner per register per clock state
`include "mft_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mft_timer
  import mft_pkg::*;
(
  input wire logic hclk,          // Clock
  input wire logic hresetn,       // Async reset, active low
  mft_if.dev bus,                 // CPU-side timer bus and pins
  input wire logic [2:0] cap_pin, // Capture input pins, async
  input wire logic [2:0] dma_clr, // DMA trigger clears flag A
  input wire logic standby        // Standby request, same clock
);
  mft_word_t cnt [3];         // Counters
  mft_word_t ra [3];          // Compare/capture A
  mft_word_t rb [3];          // Compare/capture B
  mft_word_t rc [3];          // Compare/capture C, buffer of A
  mft_word_t rd [3];          // Compare/capture D, buffer of B
  logic [`MFT_CTRL_W-1:0] ctl [3]; // Control
  logic [3:0] ioc [3];        // I/O control
  mft_mode_e mode [3];        // Operating mode
  logic [2:0] req;            // Count request before suppression
  logic [2:0] ovf;            // Overflow event
  logic [2:0] unf;            // Underflow event
  logic [2:0] ev_a;           // A match or capture
  logic [2:0] cnt_wr;         // Counter write in T2
  logic [8:0] flg;            // Status flags, three per channel
  logic [2:0] pa_reg;         // Pin A level
  logic [2:0] pc_reg;         // Pin C level
  mft_word_t rdata_reg;       // Read data
  logic [2:0] cs1, cs2, cs3;  // Capture pin synchroniser and edge

  // Address match for one channel register
  function automatic logic hit(input logic [5:0] a, input logic [1:0] ch,
                               input logic [3:0] r);
    hit = (a == {ch, r});
  endfunction

  assign bus.tpin_a = pa_reg;
  assign bus.tpin_c = pc_reg;
  assign bus.rdata = rdata_reg;

  // Two-flop synchroniser then edge stage for capture pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cs1 <= 3'h0;
      cs2 <= 3'h0;
      cs3 <= 3'h0;
    end else begin
      cs1 <= cap_pin;
      cs2 <= cs1;
      cs3 <= cs2;
    end
  end

  genvar i, j;
  generate
    for (i = 0; i < 3; i++) begin : g_ch
      localparam logic [1:0] CH = 2'(i);
      logic wr2, w_a, w_b, w_c, w_d, w_io, rd_st, w_st;
      logic up, inc, cap_a, mt_a, mt_b, mt_c, mt_d, clr, blk_c, casc;
      logic [2:0] setv;
      assign wr2 = bus.t2 && bus.wr;
      assign cnt_wr[i] = wr2 && hit(bus.addr, CH, `MFT_R_COUNT);
      assign w_a = wr2 && hit(bus.addr, CH, `MFT_R_CCA);
      assign w_b = wr2 && hit(bus.addr, CH, `MFT_R_CCB);
      assign w_c = wr2 && hit(bus.addr, CH, `MFT_R_CCC);
      assign w_d = wr2 && hit(bus.addr, CH, `MFT_R_CCD);
      assign w_io = wr2 && hit(bus.addr, CH, `MFT_R_IOC);
      assign w_st = wr2 && hit(bus.addr, CH, `MFT_R_STAT);
      assign rd_st = bus.t2 && !bus.wr && hit(bus.addr, CH, `MFT_R_STAT);
      // Cascade only on channel 1, fed by channel 2 wrap
      assign casc = (i == 1) && ctl[i][`MFT_C_CASC];
      assign req[i] = ctl[i][`MFT_C_RUN] &&
                      (casc ? (ovf[2] || unf[2]) : 1'b1);
      // Count suppressed when channel 2 is written in contention
      assign inc = req[i] && !(casc && cnt_wr[2]); // [R9]
      // Down counting only in phase mode on channels 1 and 2
      assign up = !(mode[i] == MFT_PHASE && ctl[i][`MFT_C_DOWN]);
      // Channel 0 may capture on the channel 1 count clock
      assign cap_a = ctl[i][`MFT_C_CAPA] &&
                     (((i == 0) && ctl[i][`MFT_C_CAPSRC]) ? req[1] :
                      (cs2[i] && !cs3[i])); // [R10]
      // Matches use the request, so cascade contention keeps them
      assign mt_a = req[i] && !ctl[i][`MFT_C_CAPA] && cnt[i] == ra[i]; // [R10]
      assign mt_b = req[i] && cnt[i] == rb[i];
      assign mt_c = req[i] && cnt[i] == rc[i];
      assign mt_d = req[i] && cnt[i] == rd[i];
      assign ev_a[i] = mt_a || cap_a;
      assign clr = ctl[i][`MFT_C_CLRA] && ev_a[i];
      assign ovf[i] = inc && up && cnt[i] == 16'hFFFF;
      assign unf[i] = inc && !up && cnt[i] == 16'h0000;
      // Pin C frozen by buffering in PWM1, except D-only on channel 0
      assign blk_c = mode[i] == MFT_PWM1 && (ctl[i][`MFT_C_BUFC] ||
                     (ctl[i][`MFT_C_BUFD] && i != 0)); // [R15] [R16]
      // Overflow and underflow flags lost when the counter is cleared or written
      assign setv = {unf[i] && !clr && !cnt_wr[i],
                     ovf[i] && !clr && !cnt_wr[i], // [R12] [R13]
                     ev_a[i]};

      // Counter: clear, then write, then count
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt[i] <= 16'h0000;
        end else if (clr) begin
          cnt[i] <= 16'h0000; // [R1] [R2] [R12] [R23]
        end else if (cnt_wr[i]) begin
          cnt[i] <= bus.wdata; // [R3] [R13]
        end else if (inc) begin
          cnt[i] <= up ? cnt[i] + 16'h0001 : cnt[i] - 16'h0001;
        end
      end

      // Register A: capture, then buffer transfer, then write
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ra[i] <= `MFT_CC_RST;
        end else if (cap_a) begin
          ra[i] <= cnt[i]; // [R6] [R23]
        end else if (ctl[i][`MFT_C_BUFC] && mt_a) begin
          ra[i] <= (i == 0 && w_c) ? bus.wdata : rc[i]; // [R4]
        end else if (w_a) begin
          ra[i] <= bus.wdata; // [R8]
        end
      end

      // Register C: capture shift beats a CPU write
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rc[i] <= `MFT_CC_RST;
        end else if (cap_a && ctl[i][`MFT_C_BUFC]) begin
          rc[i] <= ra[i]; // [R7]
        end else if (w_c) begin
          rc[i] <= bus.wdata;
        end
      end

      // Register B: channel 1 capture on channel 0 A event
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rb[i] <= `MFT_CC_RST;
        end else if (i == 1 && ctl[i][`MFT_C_CAPB] && ev_a[0]) begin
          rb[i] <= cnt[i]; // [R10]
        end else if (ctl[i][`MFT_C_BUFD] && mt_b) begin
          rb[i] <= rd[i];
        end else if (w_b) begin
          rb[i] <= bus.wdata;
        end
      end

      // Register D, control, I/O control and mode writes
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rd[i] <= `MFT_CC_RST;
          ctl[i] <= `MFT_CTRL_RST;
          ioc[i] <= `MFT_IOC_RST;
          mode[i] <= MFT_NORMAL;
        end else begin
          if (w_d) begin
            rd[i] <= bus.wdata;
          end
          if (wr2 && hit(bus.addr, CH, `MFT_R_CTRL)) begin
            ctl[i] <= bus.wdata[`MFT_CTRL_W-1:0];
          end
          if (w_io) begin
            ioc[i] <= bus.wdata[3:0];
          end
          if (wr2 && hit(bus.addr, CH, `MFT_R_MODE)) begin
            // Phase counting refused on channel 0
            mode[i] <= (i == 0 && bus.wdata[1:0] == MFT_PHASE) ?
                       MFT_NORMAL : mft_mode_e'(bus.wdata[1:0]); // [R18]
          end
        end
      end

      // Pin A: init on I/O write, A sets except in PWM2, B resets in PWM1
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pa_reg[i] <= 1'b0; // [R19]
        end else if (standby) begin
          pa_reg[i] <= 1'b0; // [R19]
        end else if (w_io) begin
          pa_reg[i] <= bus.wdata[`MFT_IO_INITA];
        end else if (mode[i] == MFT_PWM1 && mt_b) begin
          pa_reg[i] <= !ioc[i][`MFT_IO_LVLA]; // [R14]
        end else if (mt_a && mode[i] != MFT_PWM2) begin
          pa_reg[i] <= ioc[i][`MFT_IO_LVLA]; // [R18]
        end
      end

      // Pin C: same pairing with C and D, unless frozen
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pc_reg[i] <= 1'b0;
        end else if (standby) begin
          pc_reg[i] <= 1'b0; // [R19]
        end else if (blk_c) begin
          pc_reg[i] <= pc_reg[i]; // [R15]
        end else if (w_io) begin
          pc_reg[i] <= bus.wdata[`MFT_IO_INITC]; // [R16]
        end else if (mode[i] == MFT_PWM1 && mt_d) begin
          pc_reg[i] <= !ioc[i][`MFT_IO_LVLC]; // [R14]
        end else if (mt_c) begin
          pc_reg[i] <= ioc[i][`MFT_IO_LVLC];
        end
      end

      // Status flags of this channel
      for (j = 0; j < 3; j++) begin : g_flag
        mft_flag u_flag (
          .hclk(hclk),
          .hresetn(hresetn),
          .set(setv[j]),
          .rd(rd_st),
          .wr0(w_st && !bus.wdata[j]), // [R22]
          .dma_clr(dma_clr[i] && j == 0),
          .flag(flg[i*3+j])
        );
      end
    end
  endgenerate

  // Read data latched in T2, after any capture taken in T1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 16'h0000;
    end else if (bus.t2 && !bus.wr) begin
      rdata_reg <= 16'h0000;
      for (int k = 0; k < 3; k++) begin
        if (bus.addr[5:4] == k[1:0]) begin
          case (bus.addr[3:0])
            `MFT_R_COUNT: rdata_reg <= cnt[k];
            `MFT_R_CCA: rdata_reg <= ra[k]; // [R5]
            `MFT_R_CCB: rdata_reg <= rb[k];
            `MFT_R_CCC: rdata_reg <= rc[k];
            `MFT_R_CCD: rdata_reg <= rd[k];
            `MFT_R_CTRL: rdata_reg <= {7'h00, ctl[k]};
            `MFT_R_IOC: rdata_reg <= {12'h000, ioc[k]};
            `MFT_R_STAT: rdata_reg <= {13'h0000, flg[k*3 +: 3]};
            `MFT_R_MODE: rdata_reg <= {14'h0000, mode[k]};
            default: rdata_reg <= 16'h0000;
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: hdl/mft_cpu.sv
`include "mft_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mft_cpu
  import mft_pkg::*;
(
  input wire logic hclk,           // Clock
  input wire logic hresetn,        // Async reset, active low
  mft_if.cpu bus,                  // Timer bus and timer pin levels
  input wire logic hsel,           // AHB slave select
  input wire logic [31:0] haddr,   // AHB address
  input wire logic [1:0] htrans,   // AHB transfer type
  input wire logic hwrite,         // AHB write
  input wire logic [2:0] hsize,    // AHB size, word only
  input wire logic [31:0] hwdata,  // AHB write data
  input wire logic hready,         // AHB bus ready
  output logic hreadyout,          // Slave ready, low in reset, high from the first clock after
  output logic hresp,              // Always OKAY
  output logic [31:0] hrdata,      // AHB read data
  output logic [5:0] port_out,     // Pins a0..a2, c0..c2
  output logic [5:0] port_oe       // Pin drive enables
);
  logic ap_wr;             // Data phase of a write
  logic [7:0] ap_addr;     // Latched address
  logic [5:0] cmd_addr;    // Timer register to access
  logic cmd_wr;            // Access is a write
  mft_word_t cmd_wdata;    // Data to write
  mft_word_t last_rdata;   // Data of the last read
  logic [23:0] pin_cfg;    // Pin function settings
  mft_bus_e st;            // Timer bus cycle state

  // Read value of a controller register
  function automatic logic [31:0] rd_val(input logic [7:0] a);
    case (a)
      `MFT_H_ADDR: rd_val = {25'h0000000, cmd_wr, cmd_addr};
      `MFT_H_WDATA: rd_val = {16'h0000, cmd_wdata};
      `MFT_H_GO: rd_val = {31'h00000000, st != MFT_IDLE};
      `MFT_H_RDATA: rd_val = {16'h0000, last_rdata};
      `MFT_H_PIN: rd_val = {8'h00, pin_cfg};
      default: rd_val = 32'h00000000;
    endcase
  endfunction

  // Address phase capture; read data prepared for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ap_wr <= hsel && htrans[1] && hwrite && hready;
      ap_addr <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite && hready) begin
        hrdata <= rd_val(haddr[7:0]);
      end
    end
  end

  // Register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_addr <= 6'h00;
      cmd_wr <= 1'b0;
      cmd_wdata <= 16'h0000;
      pin_cfg <= 24'h000000;
    end else if (ap_wr) begin
      case (ap_addr)
        `MFT_H_ADDR: begin
          cmd_addr <= hwdata[5:0];
          cmd_wr <= hwdata[6];
        end
        `MFT_H_WDATA: cmd_wdata <= hwdata[15:0];
        `MFT_H_PIN: pin_cfg <= hwdata[23:0];
        default: cmd_addr <= cmd_addr;
      endcase
    end
  end

  // Timer bus cycle: T1, T2, then read data taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= MFT_IDLE;
      bus.t1 <= 1'b0;
      bus.t2 <= 1'b0;
      bus.wr <= 1'b0;
      bus.addr <= 6'h00;
      bus.wdata <= 16'h0000;
      last_rdata <= 16'h0000;
    end else begin
      case (st)
        MFT_IDLE: begin
          if (ap_wr && ap_addr == `MFT_H_GO && hwdata[0]) begin
            st <= MFT_T1;
            bus.t1 <= 1'b1;
            bus.wr <= cmd_wr;
            bus.addr <= cmd_addr;
          end
        end
        MFT_T1: begin
          st <= MFT_T2;
          bus.t1 <= 1'b0;
          bus.t2 <= 1'b1;
          bus.wdata <= cmd_wdata; // [R22]
        end
        MFT_T2: begin
          st <= MFT_DONE;
          bus.t2 <= 1'b0;
        end
        MFT_DONE: begin
          st <= MFT_IDLE;
          if (!bus.wr) begin
            last_rdata <= bus.rdata;
          end
        end
        default: st <= MFT_IDLE;
      endcase
    end
  end

  // Pin function: timer level or port level, shown one clock later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_out <= 6'h00;
      port_oe <= 6'h00;
    end else begin
      for (int k = 0; k < 6; k++) begin
        if (pin_cfg[`MFT_P_SEL + k]) begin
          port_out[k] <= (k < 3) ? bus.tpin_a[k % 3] :
                         bus.tpin_c[k % 3]; // [R20]
        end else begin
          port_out[k] <= pin_cfg[`MFT_P_LVL + k]; // [R21]
        end
      end
      port_oe <= pin_cfg[`MFT_P_OE +: 6];
    end
  end
endmodule
`default_nettype wire

// File: testbench/mft_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mft_monitor
  import mft_pkg::*;
(
  input wire logic hclk,         // Clock
  input wire logic hresetn,      // Async reset, active low
  input wire logic t1,           // First bus state
  input wire logic t2,           // Second bus state
  input wire logic wr,           // Write cycle
  input wire logic [5:0] addr,   // Channel and register
  input wire mft_word_t wdata,   // Write data
  input wire mft_word_t rdata,   // Read data
  input wire logic [2:0] tpin_a, // Pin A levels
  input wire logic [2:0] tpin_c  // Pin C levels
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // One first state, then one second state
  sequence seq_cycle;
    t1 ##1 t2;
  endsequence
  // Bus quiet for the closing state
  sequence seq_quiet;
    !t1 && !t2;
  endsequence
  chk_cycle_order: assert property (t1 |-> seq_cycle)
    else $error("second state missing");
  chk_t2_cause: assert property (t2 |-> $past(t1))
    else $error("second state without first");
  chk_one_state: assert property (!(t1 && t2))
    else $error("two states at once");
  chk_done_gap: assert property (t2 |=> seq_quiet)
    else $error("no closing state");
  chk_addr_hold: assert property (t1 |=> $stable(addr) && $stable(wr))
    else $error("address moved in cycle");
  chk_rdata_hold: assert property ((!t2 || wr) |=> $stable(rdata))
    else $error("read data moved without read");
  chk_pins_reset: assert property ($rose(hresetn) |->
    tpin_a == 3'h0 && tpin_c == 3'h0)
    else $error("pins not low after reset");
  chk_mode_ch0: assert property ((t2 && !wr && addr == 6'h08)
    |=> rdata[1:0] != 2'h3)
    else $error("channel 0 holds phase mode");
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  error_cnt++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb;
  import mft_pkg::*;
  logic hclk = 1'b0; // Clock
  logic hresetn = 1'b0; // Reset, active low
  logic hsel = 1'b0; // Slave select
  logic hwrite = 1'b0; // Write transfer
  logic standby = 1'b0; // Standby request
  logic [1:0] htrans = 2'h0; // Transfer type
  logic [2:0] hsize = 3'h2; // Word size
  logic [31:0] haddr = 32'h0; // Address
  logic [31:0] hwdata = 32'h0; // Write data
  logic [2:0] cap_pin = 3'h0; // Capture pins
  logic [2:0] dma_clr = 3'h0; // DMA clear pulses
  wire logic hreadyout; // Slave ready
  wire logic hresp; // Response
  wire logic [31:0] hrdata; // Read data
  wire logic [5:0] port_out; // Port levels
  wire logic [5:0] port_oe; // Port enables
  int error_cnt = 0; // Mismatches
  int tests_run = 0; // Comparisons
  mft_word_t q; // Last timer read
  mft_if u_mft_if (.hclk(hclk), .hresetn(hresetn));
  mft_timer u_mft_timer (.hclk(hclk), .hresetn(hresetn), .bus(u_mft_if),
    .cap_pin(cap_pin), .dma_clr(dma_clr), .standby(standby));
  mft_cpu u_mft_cpu (.hclk(hclk), .hresetn(hresetn), .bus(u_mft_if),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .port_out(port_out), .port_oe(port_oe));
  mft_monitor u_mft_monitor (.hclk(hclk), .hresetn(hresetn),
    .t1(u_mft_if.t1), .t2(u_mft_if.t2), .wr(u_mft_if.wr),
    .addr(u_mft_if.addr), .wdata(u_mft_if.wdata), .rdata(u_mft_if.rdata),
    .tpin_a(u_mft_if.tpin_a), .tpin_c(u_mft_if.tpin_c));
  // Clock toggles every half period
  always #10 hclk = ~hclk;
  // Counts, verdict and end of run
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Waits for ready at a rising edge, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        `CHK("ready", 1'b1, 1'b0)
        final_report();
      end
      @(posedge hclk);
    end
  endtask
  // One single word transfer
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  // One timer register access through the controller
  task automatic tacc(input logic w, input logic [1:0] ch,
                      input logic [3:0] rg, input mft_word_t d);
    logic [31:0] r;
    int n;
    n = 0;
    ahb(1'b1, 8'h04, {16'h0, d}, r);
    ahb(1'b1, 8'h00, {25'h0, w, ch, rg}, r);
    ahb(1'b1, 8'h08, 32'h1, r);
    do begin
      ahb(1'b0, 8'h08, 32'h0, r);
      n++;
      if (n > 20) begin
        `CHK("busy", 1'b0, 1'b1)
        final_report();
      end
    end while (r[0] === 1'b1);
    ahb(1'b0, 8'h0C, 32'h0, r);
    q = r[15:0];
  endtask
  // Pins after reset, port cutoff and standby
  task automatic t_pins();
    logic [31:0] r;
    `CHK("pins a", 3'h0, u_mft_if.tpin_a)
    tacc(1'b1, 2'h0, 4'h6, 16'h4);
    ahb(1'b1, 8'h10, 32'h0001_0001, r);
    repeat (3) @(posedge hclk);
    `CHK("port a0", 2'h3, {port_oe[0], port_out[0]})
    ahb(1'b1, 8'h10, 32'h0001_0000, r);
    repeat (3) @(posedge hclk);
    `CHK("cutoff a0", 2'h2, {port_oe[0], port_out[0]})
    standby <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK("standby a", 3'h0, u_mft_if.tpin_a)
    standby <= 1'b0;
  endtask
  // Every mode on every channel
  task automatic t_modes();
    for (int c = 0; c < 3; c++) begin
      for (int m = 0; m < 4; m++) begin
        tacc(1'b1, c[1:0], 4'h8, m[15:0]);
        tacc(1'b0, c[1:0], 4'h8, 16'h0);
        `CHK("mode", (c == 0 && m == 3) ? 2'h0 : m[1:0], q[1:0])
      end
      tacc(1'b1, c[1:0], 4'h8, 16'h0);
    end
  endtask
  // Pin C under PWM1 with buffer settings
  task automatic t_pwm();
    logic [1:0] ch[5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1};
    logic [15:0] ct[5] = '{16'h18, 16'h8, 16'h10, 16'h10, 16'h0};
    logic ex[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 5; i++) begin
      tacc(1'b1, ch[i], 4'h8, 16'h1);
      tacc(1'b1, ch[i], 4'h5, ct[i]);
      tacc(1'b1, ch[i], 4'h6, 16'h8);
      repeat (2) @(posedge hclk);
      `CHK("pin c", ex[i], u_mft_if.tpin_c[ch[i]])
      tacc(1'b1, ch[i], 4'h5, 16'h0);
      tacc(1'b1, ch[i], 4'h8, 16'h0);
    end
  endtask
  // Clear on match bounds the count
  task automatic t_period();
    tacc(1'b1, 2'h0, 4'h1, 16'h3);
    tacc(1'b1, 2'h0, 4'h5, 16'h3);
    for (int i = 0; i < 6; i++) begin
      tacc(1'b0, 2'h0, 4'h0, 16'h0);
      `CHK("count", 1'b1, q <= 16'h3)
    end
    tacc(1'b1, 2'h0, 4'h5, 16'h0);
  endtask
  // Bus writes against clear, count, wrap, cascade and capture
  task automatic t_race();
    tacc(1'b1, 2'h0, 4'h1, 16'h0020);
    tacc(1'b1, 2'h0, 4'h0, 16'h0013);
    tacc(1'b1, 2'h0, 4'h5, 16'h0003);
    // Second state of this write lands on the match at 0x20
    tacc(1'b1, 2'h0, 4'h0, 16'h0100);
    tacc(1'b0, 2'h0, 4'h0, 16'h0000);
    `CHK("clear wins", 16'h000D, q)
    tacc(1'b1, 2'h0, 4'h5, 16'h0001);
    tacc(1'b1, 2'h0, 4'h0, 16'hFFF2);
    // Counter stands at 0xFFFF as this write lands
    tacc(1'b1, 2'h0, 4'h0, 16'h0010);
    tacc(1'b0, 2'h0, 4'h0, 16'h0000);
    `CHK("write wins", 16'h001D, q)
    tacc(1'b1, 2'h0, 4'h5, 16'h0000);
    tacc(1'b0, 2'h0, 4'h7, 16'h0000);
    `CHK("no wrap flag", 1'b0, q[1])
    tacc(1'b1, 2'h0, 4'h7, 16'h0000);
    // Channel 2 wraps as it is written; channel 1 must not count
    tacc(1'b1, 2'h2, 4'h0, 16'hFFF2);
    tacc(1'b1, 2'h1, 4'h5, 16'h0041);
    tacc(1'b1, 2'h2, 4'h5, 16'h0001);
    tacc(1'b1, 2'h2, 4'h0, 16'h0000);
    tacc(1'b0, 2'h1, 4'h0, 16'h0000);
    `CHK("cascade held", 16'h0000, q)
    tacc(1'b1, 2'h2, 4'h5, 16'h0000);
    tacc(1'b1, 2'h1, 4'h5, 16'h0001);
    // Channel 0 captures on every channel 1 count request
    tacc(1'b1, 2'h0, 4'h0, 16'h0055);
    tacc(1'b1, 2'h0, 4'h5, 16'h0084);
    tacc(1'b1, 2'h0, 4'h1, 16'h1234);
    tacc(1'b0, 2'h0, 4'h1, 16'h0000);
    `CHK("capture wins", 16'h0055, q)
    tacc(1'b1, 2'h0, 4'h5, 16'h008C);
    tacc(1'b1, 2'h0, 4'h3, 16'h1234);
    tacc(1'b0, 2'h0, 4'h3, 16'h0000);
    `CHK("shift wins", 16'h0055, q)
    tacc(1'b1, 2'h0, 4'h5, 16'h0000);
    tacc(1'b1, 2'h1, 4'h5, 16'h0000);
  endtask
  // Flag clearing and wrap against clear
  task automatic t_flag();
    tacc(1'b1, 2'h0, 4'h7, 16'h0);
    tacc(1'b0, 2'h0, 4'h7, 16'h0);
    `CHK("flag kept", 1'b1, q[0])
    tacc(1'b1, 2'h0, 4'h7, 16'h0);
    tacc(1'b0, 2'h0, 4'h7, 16'h0);
    `CHK("flag clear", 1'b0, q[0])
    for (int c = 1; c >= 0; c--) begin
      tacc(1'b1, 2'h0, 4'h1, 16'hFFFF);
      tacc(1'b1, 2'h0, 4'h0, 16'hFFF0);
      tacc(1'b1, 2'h0, 4'h5, c ? 16'h3 : 16'h1);
      repeat (40) @(posedge hclk);
      tacc(1'b1, 2'h0, 4'h5, 16'h0);
      tacc(1'b0, 2'h0, 4'h7, 16'h0);
      `CHK("overflow", (c == 0), q[1])
    end
    dma_clr <= 3'h1;
    @(posedge hclk);
    dma_clr <= 3'h0;
    tacc(1'b0, 2'h0, 4'h7, 16'h0);
    `CHK("dma clear", 1'b0, q[0])
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_pins();
    t_modes();
    t_pwm();
    t_period();
    t_race();
    t_flag();
    final_report();
  end
endmodule
`default_nettype wire
